// *** bench/cpu_wake_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module cpu_wake_model (
	input  wire logic i_sys_clk,
	input  wire logic i_core_rst_b,
	input  wire logic i_cpu_halt,
	input  wire logic i_irq_req,
	output logic      o_instr_done = 1'b0,
	output logic      o_irq = 1'b0
);
	// one retire per cycle while clocked; irq held until handler runs
	always @(posedge i_sys_clk) begin
		o_instr_done <= i_core_rst_b && !i_cpu_halt;
		if (!i_core_rst_b || (!i_cpu_halt && !i_irq_req))
			o_irq <= 1'b0;
		else if (i_irq_req)
			o_irq <= 1'b1;
	end
endmodule : cpu_wake_model
`default_nettype wire

// *** bench/low_power_mode_control_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module low_power_mode_control_asserts
	import power_mode_pkg::*;
#(
	parameter int MCD_LIMIT = 20
) (
	input wire logic        i_sys_clk,
	input wire logic        i_rst_b,
	input wire logic        i_sfr_rd,
	input wire logic        i_irq_asserted,
	input wire logic        i_wdt_enable,
	input wire logic        i_wdt_expire,
	input wire logic        i_mcd_enable,
	input wire logic [7:0]  o_sfr_rdata,
	input wire logic        o_cpu_halt,
	input wire logic        o_periph_run,
	input wire logic        o_precise_osc_en,
	input wire logic        o_lp_osc_en,
	input wire logic        o_core_rst_b,
	input wire logic [15:0] o_fetch_addr,
	input wire power_mode_e o_power_mode
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	int stop_cnt;
	int next_stop_cnt;
	// cycles spent in stop with the detector armed
	always_comb begin
		next_stop_cnt = 0;
		if (o_power_mode == MODE_STOP && i_mcd_enable)
			next_stop_cnt = stop_cnt + 1;
	end
	always_ff @(posedge i_sys_clk) begin
		stop_cnt <= i_rst_b ? next_stop_cnt : 0;
	end
	idle_outputs_a: assert property (o_power_mode == MODE_IDLE |->
		o_cpu_halt && o_periph_run && o_precise_osc_en)
		else $error("idle outputs wrong");
	stop_outputs_a: assert property (o_power_mode == MODE_STOP |->
		o_cpu_halt && !o_precise_osc_en && o_lp_osc_en)
		else $error("stop outputs wrong");
	idle_exit_a: assert property (o_power_mode == MODE_IDLE &&
		i_irq_asserted |-> ##[1:3] (o_power_mode == MODE_RUN && !o_cpu_halt))
		else $error("idle not left on interrupt");
	stop_stays_a: assert property (o_power_mode == MODE_STOP &&
		i_irq_asserted && !i_mcd_enable && o_core_rst_b
		|=> o_power_mode == MODE_STOP) else $error("stop left without reset");
	mcd_bound_a: assert property (stop_cnt <= MCD_LIMIT + 6)
		else $error("detector did not end stop");
	wdt_reset_a: assert property (o_power_mode == MODE_IDLE &&
		i_wdt_enable && i_wdt_expire |-> ##[1:3] !o_core_rst_b)
		else $error("watchdog did not reset");
	rst_hold_a: assert property ($fell(o_core_rst_b) |->
		!o_core_rst_b [*4]) else $error("core reset too short");
	restart_vec_a: assert property ($rose(o_core_rst_b) |->
		o_fetch_addr == RESET_VECTOR && o_power_mode == MODE_RUN)
		else $error("restart state wrong");
	rdata_rest_a: assert property (!i_sfr_rd |=> o_sfr_rdata == 8'h00)
		else $error("read data not zero");
endmodule : low_power_mode_control_asserts
`default_nettype wire

// *** bench/low_power_mode_control_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module low_power_mode_control_tb_top;
	import power_mode_pkg::*;
	localparam int MISSING_CLOCK_DETECTOR = 20;
	localparam logic [7:0] CT = PWR_CTRL_ADDR;
	localparam logic [7:0] CF = PWR_UNIT_CFG_ADDR;
	logic i_sys_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic wdt_en = 1'b0;
	logic wdt_exp = 1'b0;
	logic mcd_en = 1'b0;
	logic pin_b = 1'b1;
	logic irq_req = 1'b0;
	wake_src_s wake = '0;
	logic [7:0] rdata;
	logic done, irq, halt, periph, precise, lp, core_rst_b, wdt_run;
	logic [15:0] fetch;
	power_mode_e mode;
	int n_mismatch = 0;
	int compares = 0;
	int exp_gp;
	int exp_flags;
	logic [31:0] seed = 32'h23d3;
	always #12.5 i_sys_clk = ~i_sys_clk;
	low_power_mode_control #(.MCD_LIMIT(MISSING_CLOCK_DETECTOR)) uut (.i_sys_clk(i_sys_clk),
		.i_rst_b(i_rst_b), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
		.i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .i_instr_done(done),
		.i_irq_asserted(irq), .i_wdt_enable(wdt_en), .i_wdt_expire(wdt_exp),
		.i_mcd_enable(mcd_en), .i_rst_pin_b(pin_b), .i_wake(wake),
		.o_cpu_halt(halt), .o_periph_run(periph), .o_precise_osc_en(precise),
		.o_lp_osc_en(lp), .o_wdt_run(wdt_run), .o_core_rst_b(core_rst_b),
		.o_fetch_addr(fetch), .o_power_mode(mode));
	cpu_wake_model cpu (.i_sys_clk(i_sys_clk), .i_core_rst_b(core_rst_b),
		.i_cpu_halt(halt), .i_irq_req(irq_req), .o_instr_done(done),
		.o_irq(irq));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic chk_mode(input power_mode_e e);
		check(16'(mode), 16'(e));
	endtask : chk_mode
	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask : tick
	// one register cycle, write or read
	task automatic bus(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge i_sys_clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		@(posedge i_sys_clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
	endtask : bus
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		bus(a, 8'h00, 1'b0);
		check(16'(rdata), 16'(e));
	endtask : rd_chk
	// one-cycle pulse on a wake source
	task automatic pulse_wake(input logic [3:0] w);
		@(posedge i_sys_clk);
		wake <= w;
		@(posedge i_sys_clk);
		wake <= '0;
	endtask : pulse_wake
	task automatic wait_rst(input int lim);
		int i;
		i = 0;
		while (core_rst_b !== 1'b0 && i < lim) begin
			tick(1);
			i++;
		end
		check(16'(core_rst_b), 16'h0000);
	endtask : wait_rst
	task automatic print_verdict();
		if (n_mismatch == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict
	// hang guard
	initial begin
		repeat (5000) @(posedge i_sys_clk);
		n_mismatch++;
		print_verdict();
	end
	initial begin
		repeat (5) @(posedge i_sys_clk);
		i_rst_b <= 1'b1;
		tick(2);
		rd_chk(CT, 8'h00);
		rd_chk(CF, 8'h00);
		rd_chk(8'h55, 8'h00);
		seed = xs(seed);
		exp_gp = int'(seed[7:0]) & 8'hfc;
		bus(CT, 8'(exp_gp), 1'b1);
		rd_chk(CT, 8'(exp_gp));
		// wake flags block sleep until cleared
		bus(CF, 8'h0f, 1'b1);
		seed = xs(seed);
		exp_flags = int'(seed[3:0]) | 1;
		pulse_wake(4'(exp_flags));
		rd_chk(CF, 8'(exp_flags));
		bus(CF, 8'h8f, 1'b1);
		tick(3);
		chk_mode(MODE_RUN);
		check(16'(lp), 16'h0001);
		bus(CF, 8'h20, 1'b1);
		rd_chk(CF, 8'h00);
		for (int k = 0; k < 2; k++) begin
			bus(CF, k ? 8'h41 : 8'h81, 1'b1);
			tick(3);
			chk_mode(k ? MODE_SUSPEND : MODE_SLEEP);
			check(16'(lp), 16'(k));
			pulse_wake(4'h1);
			tick(3);
			chk_mode(MODE_RUN);
			rd_chk(CF, 8'h01);
			bus(CF, 8'h20, 1'b1);
		end
		// idle then interrupt wake
		bus(CT, 8'(exp_gp | 1), 1'b1);
		tick(3);
		chk_mode(MODE_IDLE);
		check(16'({halt, periph, precise, wdt_run}), 16'h000e);
		@(posedge i_sys_clk);
		irq_req <= 1'b1;
		@(posedge i_sys_clk);
		irq_req <= 1'b0;
		tick(4);
		chk_mode(MODE_RUN);
		check(16'(halt), 16'h0000);
		rd_chk(CT, 8'(exp_gp));
		// watchdog ends idle
		wdt_en <= 1'b1;
		bus(CT, 8'(exp_gp | 1), 1'b1);
		tick(3);
		check(16'(wdt_run), 16'h0001);
		wdt_exp <= 1'b1;
		@(posedge i_sys_clk);
		wdt_exp <= 1'b0;
		wait_rst(10);
		check(fetch, RESET_VECTOR);
		tick(8);
		chk_mode(MODE_RUN);
		wdt_en <= 1'b0;
		// stop holds through interrupts, detector ends it
		bus(CT, 8'(exp_gp | 2), 1'b1);
		tick(3);
		chk_mode(MODE_STOP);
		check(16'({periph, precise, lp}), 16'h0001);
		irq_req <= 1'b1;
		tick(4);
		chk_mode(MODE_STOP);
		mcd_en <= 1'b1;
		irq_req <= 1'b0;
		wait_rst(MISSING_CLOCK_DETECTOR + 10);
		tick(8);
		chk_mode(MODE_RUN);
		mcd_en <= 1'b0;
		// reset pin sets its wake flag
		pin_b <= 1'b0;
		tick(6);
		pin_b <= 1'b1;
		tick(12);
		rd_chk(CF, 8'h10);
		print_verdict();
	end
endmodule : low_power_mode_control_tb_top
bind low_power_mode_control low_power_mode_control_asserts #(
	.MCD_LIMIT(MCD_LIMIT)) chk (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
	.i_sfr_rd(i_sfr_rd), .i_irq_asserted(i_irq_asserted),
	.i_wdt_enable(i_wdt_enable), .i_wdt_expire(i_wdt_expire),
	.i_mcd_enable(i_mcd_enable), .o_sfr_rdata(o_sfr_rdata),
	.o_cpu_halt(o_cpu_halt), .o_periph_run(o_periph_run),
	.o_precise_osc_en(o_precise_osc_en), .o_lp_osc_en(o_lp_osc_en),
	.o_core_rst_b(o_core_rst_b), .o_fetch_addr(o_fetch_addr),
	.o_power_mode(o_power_mode));
`default_nettype wire

// *** verilog/low_power_mode_control.sv ***
`timescale 1ns/100ps
`default_nettype none
module low_power_mode_control
	import power_mode_pkg::*;
#(
	parameter int MCD_LIMIT  = MCD_CYCLES,
	parameter int RST_HOLD   = RESET_HOLD_CYCLES
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_b,
	input  wire logic [7:0]  i_sfr_addr,
	input  wire logic        i_sfr_wr,
	input  wire logic        i_sfr_rd,
	input  wire logic [7:0]  i_sfr_wdata,
	output logic      [7:0]  o_sfr_rdata,
	input  wire logic        i_instr_done,
	input  wire logic        i_irq_asserted,
	input  wire logic        i_wdt_enable,
	input  wire logic        i_wdt_expire,
	input  wire logic        i_mcd_enable,
	input  wire logic        i_rst_pin_b,
	input  wire wake_src_s   i_wake,
	output logic             o_cpu_halt,
	output logic             o_periph_run,
	output logic             o_precise_osc_en,
	output logic             o_lp_osc_en,
	output logic             o_wdt_run,
	output logic             o_core_rst_b,
	output logic      [15:0] o_fetch_addr,
	output power_mode_e      o_power_mode
);

	localparam int MCD_W = $clog2(MCD_LIMIT + 1);
	localparam int RST_W = $clog2(RST_HOLD + 1);

	// modes in which the precision oscillator and peripheral clocks run
	function automatic logic fast_clocks_on(input power_mode_e m);
		return (m == MODE_RUN) || (m == MODE_IDLE);
	endfunction : fast_clocks_on

	// pin synchroniser: three stages, change counts when 2nd and 3rd agree
	logic [2:0] pin_sync;
	logic [2:0] next_pin_sync;
	logic       pin_low;
	logic       next_pin_low;

	always_comb begin
		next_pin_sync = {pin_sync[1:0], i_rst_pin_b};
		next_pin_low  = pin_low;
		if (pin_sync[1] == pin_sync[2]) begin
			next_pin_low = ~pin_sync[2];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			pin_sync <= 3'b111;
			pin_low  <= 1'b0;
		end else begin
			pin_sync <= next_pin_sync;
			pin_low  <= next_pin_low;
		end
	end

	// register decode
	logic       wr_ctrl;
	logic       wr_cfg;
	logic       rd_ctrl;
	logic       rd_cfg;
	logic [7:0] cfg_rdata;
	logic       any_flag;
	logic       pin_fall;

	assign wr_ctrl  = i_sfr_wr & (i_sfr_addr == PWR_CTRL_ADDR);
	assign wr_cfg   = i_sfr_wr & (i_sfr_addr == PWR_UNIT_CFG_ADDR);
	assign rd_ctrl  = i_sfr_rd & (i_sfr_addr == PWR_CTRL_ADDR);
	assign rd_cfg   = i_sfr_rd & (i_sfr_addr == PWR_UNIT_CFG_ADDR);
	// one-cycle pulse once the synced pin is seen low
	assign pin_fall = next_pin_low & ~pin_low;

	// wake-up enables and flags
	wake_flag_unit u_wake (
		.i_sys_clk    (i_sys_clk),
		.i_rst_b      (i_rst_b),
		.i_cfg_wr     (wr_cfg),
		.i_cfg_wdata  (i_sfr_wdata),
		.i_wake       (i_wake),
		.i_pin_glitch (pin_fall),
		.o_cfg_rdata  (cfg_rdata),
		.o_any_flag   (any_flag)
	);

	// internal reset sources
	logic             wdt_fire;
	logic             mcd_fire;
	logic             int_rst;
	logic [MCD_W-1:0] mcd_cnt;
	logic [MCD_W-1:0] next_mcd_cnt;
	power_mode_e      state;

	assign wdt_fire = i_wdt_enable & i_wdt_expire
		& fast_clocks_on(state);
	// detector fires on its last counted cycle in stop
	assign mcd_fire = (state == MODE_STOP) & i_mcd_enable
		& (mcd_cnt == MCD_W'(MCD_LIMIT - 1));
	assign int_rst  = wdt_fire | mcd_fire | pin_fall;

	// missing-clock detector timeout while stopped
	always_comb begin
		next_mcd_cnt = '0;
		if (state == MODE_STOP && i_mcd_enable && !mcd_fire) begin
			next_mcd_cnt = mcd_cnt + MCD_W'(1);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			mcd_cnt <= '0;
		end else begin
			mcd_cnt <= next_mcd_cnt;
		end
	end

	// mode request bits and retire pulses
	logic [5:0] gp_flags;
	logic       idle_sel;
	logic       stop_sel;
	logic       idle_go;
	logic       stop_go;
	logic [5:0] next_gp_flags;
	logic       next_idle_sel;
	logic       next_stop_sel;
	logic       next_idle_go;
	logic       next_stop_go;

	always_comb begin
		next_gp_flags = gp_flags;
		next_idle_sel = idle_sel;
		next_stop_sel = stop_sel;
		if (wr_ctrl) begin
			next_gp_flags = i_sfr_wdata[7:CTRL_GP_LSB];
			next_idle_sel = idle_sel | i_sfr_wdata[CTRL_IDLE_BIT];
			next_stop_sel = stop_sel | i_sfr_wdata[CTRL_STOP_BIT];
		end
		// pulse once the setting instruction retires
		next_idle_go = i_instr_done & next_idle_sel & ~idle_go
			& (state == MODE_RUN);
		next_stop_go = i_instr_done & next_stop_sel & ~stop_go
			& (state == MODE_RUN);
		if (state == MODE_IDLE && i_irq_asserted) begin
			next_idle_sel = 1'b0;
		end
		// an internal reset drops every pending request
		if (int_rst) begin
			next_idle_sel = 1'b0;
			next_stop_sel = 1'b0;
			next_idle_go  = 1'b0;
			next_stop_go  = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			gp_flags <= CTRL_GP_RESET;
			idle_sel <= 1'b0;
			stop_sel <= 1'b0;
			idle_go  <= 1'b0;
			stop_go  <= 1'b0;
		end else begin
			gp_flags <= next_gp_flags;
			idle_sel <= next_idle_sel;
			stop_sel <= next_stop_sel;
			idle_go  <= next_idle_go;
			stop_go  <= next_stop_go;
		end
	end

	// power mode state machine
	power_mode_e    next_state;
	logic           sleep_req;
	logic           suspend_req;
	logic [RST_W-1:0] rst_cnt;
	logic [RST_W-1:0] next_rst_cnt;

	assign sleep_req   = wr_cfg & i_sfr_wdata[CFG_SLEEP_BIT];
	assign suspend_req = wr_cfg & i_sfr_wdata[CFG_SUSPEND_BIT];

	always_comb begin
		next_state   = state;
		next_rst_cnt = (rst_cnt != '0) ? rst_cnt - RST_W'(1) : rst_cnt;
		case (state)
			MODE_RUN: begin
				if (stop_go) begin
					next_state = MODE_STOP;
				end else if (idle_go) begin
					next_state = MODE_IDLE;
				end else if (sleep_req && !any_flag) begin
					next_state = MODE_SLEEP;
				end else if (suspend_req && !any_flag) begin
					next_state = MODE_SUSPEND;
				end
			end
			MODE_IDLE: begin
				if (i_irq_asserted) begin
					// core takes the pending interrupt, then resumes
					next_state = MODE_RUN;
				end
			end
			// only a reset leaves stop
			MODE_STOP: begin
				next_state = MODE_STOP;
			end
			// any pending wake flag ends sleep or suspend
			MODE_SLEEP, MODE_SUSPEND: begin
				if (any_flag) begin
					next_state = MODE_RUN;
				end
			end
			default: begin
				next_state = MODE_RUN;
			end
		endcase
		// internal reset overrides every mode
		if (int_rst) begin
			next_state   = MODE_RUN;
			next_rst_cnt = RST_W'(RST_HOLD);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			state   <= MODE_RUN;
			rst_cnt <= '0;
		end else begin
			state   <= next_state;
			rst_cnt <= next_rst_cnt;
		end
	end

	// registered outputs derived from the next mode, the reset hold count and register reads
	logic [7:0] next_rdata;
	logic       next_halt;
	logic       next_periph;
	logic       next_precise;
	logic       next_lp;
	logic       next_wdt;

	always_comb begin
		next_halt    = (next_state != MODE_RUN);
		next_periph  = fast_clocks_on(next_state);
		next_precise = fast_clocks_on(next_state);
		next_lp      = (next_state != MODE_SLEEP) || any_flag;
		next_wdt     = i_wdt_enable & next_periph;
		next_rdata   = 8'h00;
		if (rd_ctrl) begin
			next_rdata = {gp_flags, 2'b00};
		end else if (rd_cfg) begin
			next_rdata = cfg_rdata;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			o_sfr_rdata      <= 8'h00;
			o_cpu_halt       <= 1'b0;
			o_periph_run     <= 1'b1;
			o_precise_osc_en <= 1'b1;
			o_lp_osc_en      <= 1'b1;
			o_wdt_run        <= 1'b0;
			o_core_rst_b     <= 1'b0;
			o_fetch_addr     <= RESET_VECTOR;
			o_power_mode     <= MODE_RUN;
		end else begin
			o_sfr_rdata      <= next_rdata;
			o_cpu_halt       <= next_halt;
			o_periph_run     <= next_periph;
			o_precise_osc_en <= next_precise;
			o_lp_osc_en      <= next_lp;
			o_wdt_run        <= next_wdt;
			o_core_rst_b     <= (next_rst_cnt == '0);
			// restart always from the reset vector
			o_fetch_addr     <= RESET_VECTOR;
			o_power_mode     <= next_state;
		end
	end

endmodule : low_power_mode_control
`default_nettype wire

// *** verilog/power_mode_pkg.sv ***
`default_nettype none
package power_mode_pkg;

	// register addresses on the special-function bus
	localparam logic [7:0] PWR_CTRL_ADDR     = 8'h87;
	localparam logic [7:0] PWR_UNIT_CFG_ADDR = 8'hB5;

	// power_control_reg fields
	localparam int         CTRL_IDLE_BIT     = 0;
	localparam int         CTRL_STOP_BIT     = 1;
	localparam int         CTRL_GP_LSB       = 2;
	localparam logic [5:0] CTRL_GP_RESET     = 6'h00;

	// power_unit_configuration fields
	localparam int         CFG_SLEEP_BIT     = 7;
	localparam int         CFG_SUSPEND_BIT   = 6;
	localparam int         CFG_CLEAR_BIT     = 5;
	localparam int         CFG_RESET_PIN_WAKE_FLAG_BIT     = 4;
	localparam logic [3:0] WAKE_EN_RESET     = 4'h0;
	localparam logic [3:0] WAKE_FLAG_RESET   = 4'h0;

	// restart address after any reset
	localparam logic [15:0] RESET_VECTOR     = 16'h0000;

	// timing at 40 MHz
	localparam int CLK_PERIOD_NS     = 25;
	localparam int MCD_TIMEOUT_NS    = 100000;
	localparam int MCD_CYCLES        =
		(MCD_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_HOLD_CYCLES = 4;

	typedef enum logic [2:0] {
		MODE_RUN,
		MODE_IDLE,
		MODE_STOP,
		MODE_SLEEP,
		MODE_SUSPEND
	} power_mode_e;

	// wake-up event sources, bit order matches the register
	typedef struct packed {
		logic rtc_osc_fail_wake;
		logic rtc_alarm_wake;
		logic port_match_wake;
		logic comparator_zero_wake;
	} wake_src_s;

endpackage : power_mode_pkg
`default_nettype wire

// *** verilog/wake_flag_unit.sv ***
`timescale 1ns/100ps
`default_nettype none
module wake_flag_unit
	import power_mode_pkg::*;
(
	input  wire logic       i_sys_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_cfg_wr,
	input  wire logic [7:0] i_cfg_wdata,
	input  wire wake_src_s  i_wake,
	input  wire logic       i_pin_glitch,
	output logic      [7:0] o_cfg_rdata,
	output logic            o_any_flag
);

	logic [3:0] wake_en;
	logic [3:0] wake_flag;
	logic       reset_pin_wake_flag;
	logic [3:0] next_wake_en;
	logic [3:0] next_wake_flag;
	logic       next_reset_pin_wake_flag;
	logic       clr;

	// enables written, flags set by enabled events; set beats clear
	always_comb begin
		clr                      = i_cfg_wr & i_cfg_wdata[CFG_CLEAR_BIT];
		next_wake_en             = wake_en;
		next_wake_flag           = wake_flag;
		next_reset_pin_wake_flag = reset_pin_wake_flag;
		if (i_cfg_wr) begin
			next_wake_en = i_cfg_wdata[3:0];
		end
		if (clr) begin
			next_wake_flag           = 4'h0;
			next_reset_pin_wake_flag = 1'b0;
		end
		next_wake_flag = next_wake_flag | (wake_en & i_wake);
		if (i_pin_glitch) begin
			next_reset_pin_wake_flag = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			wake_en             <= WAKE_EN_RESET;
			wake_flag           <= WAKE_FLAG_RESET;
			reset_pin_wake_flag <= 1'b0;
		end else begin
			wake_en             <= next_wake_en;
			wake_flag           <= next_wake_flag;
			reset_pin_wake_flag <= next_reset_pin_wake_flag;
		end
	end

	// commands read as zero, flag bits show state
	assign o_cfg_rdata = {3'b000, reset_pin_wake_flag, wake_flag};
	assign o_any_flag  = reset_pin_wake_flag | (|wake_flag);

endmodule : wake_flag_unit
`default_nettype wire
